/* include/sfpm_consts.vh */
`ifndef SFPM_CONSTS_VH
`define SFPM_CONSTS_VH
// instruction codes
`define SFPM_CMD_SLEEP 8'hb9
`define SFPM_CMD_WAKE 8'hab
// busy flag position in volatile status register 1
`define SFPM_BUSY_BIT 0
// clock period in ns
`define SFPM_CLK_NS 50
// sleep entry delay, least time in ns
`define SFPM_SLEEP_ENTRY_NS 3000
// wake exit delay, least time in ns
`define SFPM_WAKE_EXIT_NS 5000
// cycles, rounded up
`define SFPM_SLEEP_ENTRY_CYC ((`SFPM_SLEEP_ENTRY_NS + `SFPM_CLK_NS - 1) / `SFPM_CLK_NS)
`define SFPM_WAKE_EXIT_CYC ((`SFPM_WAKE_EXIT_NS + `SFPM_CLK_NS - 1) / `SFPM_CLK_NS)
// power mode codes
`define SFPM_MODE_STANDBY 2'h0
`define SFPM_MODE_ACTIVE 2'h1
`define SFPM_MODE_SLEEP 2'h2
`endif

/* design/sfpm_shift.v */
`timescale 1ns/1ns
// captures the first byte of a frame, msb first, on synchronised clock rises
module sfpm_shift (
   // clock and reset
   input wire mclk,
   input wire rst,
   // synchronised select and data levels, and the clock rise pulse
   input wire cs_sel,
   input wire sck_rise,
   input wire si_bit,
   // result
   output reg [7:0] op_r,
   output reg op_done_r,
   output reg sck_seen_r
);
   reg [2:0] cnt_r;
   reg [7:0] sh_r;

   // shift register, restarted while chip select is high
   always @(posedge mclk) begin
      if (rst || !cs_sel) begin
         cnt_r <= 3'h0;
         sh_r <= 8'h00;
         op_r <= 8'h00;
         op_done_r <= 1'b0;
         sck_seen_r <= 1'b0;
      end else if (sck_rise) begin
         sck_seen_r <= 1'b1;
         if (!op_done_r) begin
            sh_r <= {sh_r[6:0], si_bit};
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
               op_r <= {sh_r[6:0], si_bit};
               op_done_r <= 1'b1;
            end
         end
      end
   end
endmodule

/* design/sfpm_ctrl.v */
`timescale 1ns/1ns
`include "sfpm_consts.vh"
module sfpm_ctrl #(
   parameter ENTRY_CYC = `SFPM_SLEEP_ENTRY_CYC,
   parameter WAKE_CYC = `SFPM_WAKE_EXIT_CYC
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // serial pins
   input wire cs_n,
   input wire sck,
   input wire si,
   // hardware reset pins
   input wire reset_pin_n,
   input wire shared_io_reset_pin_n,
   // busy from the memory core, volatile status register 1
   input wire [7:0] volatile_status_reg1,
   // status out
   output reg [1:0] power_mode_r,
   output reg dev_enabled_r,
   output reg deep_sleep_state_r,
   output reg waking_r,
   output reg dout_en_allow_r,
   output reg op_start_allow_r
);
   localparam ST_STBY = 3'h0;
   localparam ST_ACT = 3'h1;
   localparam ST_ENTRY = 3'h2;
   localparam ST_SLEEP = 3'h3;
   localparam ST_WAKE = 3'h4;

   // power mode code shown for each state; the wake delay still reports sleep
   function [1:0] mode_of;
      input [2:0] st_in;
      begin
         case (st_in)
            ST_ACT: mode_of = `SFPM_MODE_ACTIVE;
            // entry delay still counts as active until sleep is reached
            ST_ENTRY: mode_of = `SFPM_MODE_ACTIVE;
            ST_SLEEP: mode_of = `SFPM_MODE_SLEEP;
            ST_WAKE: mode_of = `SFPM_MODE_SLEEP;
            default: mode_of = `SFPM_MODE_STANDBY;
         endcase
      end
   endfunction

   // enable and data drive both need select low in the active state
   function sel_active;
      input sel_in;
      input [2:0] st_in;
      begin
         sel_active = sel_in && (st_in == ST_ACT);
      end
   endfunction

   // state, delay counter and the pending code flag
   reg [2:0] st_r, st_nxt;
   // sixteen bits cover the default delays with a wide margin
   reg [15:0] dly_r, dly_nxt;
   // an accepted sleep or wake code waits here until select rises
   reg pend_r, pend_nxt;
   // synchroniser stages and the delayed copies used for edge detection
   reg [1:0] cs_s, sck_s, si_s, rp_s, rq_s;
   reg sck_d_r, cs_d_r;
   // edges come from the second stage only; the first may still be settling
   wire cs_sel = ~cs_s[1];
   // limitation: sck must run slower than half of mclk, so each level lasts over one mclk period, or rises are lost
   wire sck_rise = sck_s[1] & ~sck_d_r;
   wire cs_rise = cs_s[1] & ~cs_d_r;
   // either reset pin alone forces standby once synchronised
   wire hw_reset = ~rp_s[1] | ~rq_s[1];
   wire busy_write_flag = volatile_status_reg1[`SFPM_BUSY_BIT];
   wire [7:0] op;
   wire op_done;
   wire sck_seen;

   // two-stage synchronisers for every pin
   // reset loads the idle pin levels so no false edge follows reset
   always @(posedge mclk) begin
      if (rst) begin
         cs_s <= 2'h3;
         sck_s <= 2'h0;
         si_s <= 2'h0;
         rp_s <= 2'h3;
         rq_s <= 2'h3;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         cs_s <= {cs_s[0], cs_n};
         sck_s <= {sck_s[0], sck};
         si_s <= {si_s[0], si};
         rp_s <= {rp_s[0], reset_pin_n};
         rq_s <= {rq_s[0], shared_io_reset_pin_n};
         sck_d_r <= sck_s[1];
         cs_d_r <= cs_s[1];
      end
   end

   // first byte decoder; bits after the eighth are ignored
   sfpm_shift u_shift (
      .mclk(mclk),
      .rst(rst),
      .cs_sel(cs_sel),
      .sck_rise(sck_rise),
      .si_bit(si_s[1]),
      .op_r(op),
      .op_done_r(op_done),
      .sck_seen_r(sck_seen)
   );

   // power state machine
   always @* begin
      st_nxt = st_r;
      dly_nxt = dly_r;
      pend_nxt = pend_r;
      case (st_r)
         ST_STBY: begin
            if (cs_sel) begin
               st_nxt = ST_ACT;
               pend_nxt = 1'b0;
            end
         end
         ST_ACT: begin
            // sleep code arrives in a clocked frame from standby
            // sleep code taken only when not busy
            // the code stands until select rises, so busy clearing mid-frame still lets it in
            if (cs_sel && op_done && op == `SFPM_CMD_SLEEP && !busy_write_flag) begin
               pend_nxt = 1'b1;
            end
            // wait for select rise, then entry delay
            if (!cs_sel && pend_r) begin
               st_nxt = ST_ENTRY;
               dly_nxt = ENTRY_CYC[15:0];
            end else if (!cs_sel && !busy_write_flag) begin
               st_nxt = ST_STBY;
            end
         end
         ST_ENTRY: begin
            // frames during the entry delay are not decoded; sleep follows regardless
            if (dly_r <= 16'h0001) begin
               st_nxt = ST_SLEEP;
               pend_nxt = 1'b0;
            end else begin
               dly_nxt = dly_r - 16'h0001;
            end
         end
         ST_SLEEP: begin
            // only wake code marked; others ignored
            // sck_seen guards against a clockless frame acting on a stale code
            if (cs_sel && op_done && sck_seen && op == `SFPM_CMD_WAKE) begin
               pend_nxt = 1'b1;
            end
            // select rise starts the wake delay
            if (cs_rise && pend_r) begin
               st_nxt = ST_WAKE;
               dly_nxt = WAKE_CYC[15:0];
               pend_nxt = 1'b0;
            end
         end
         ST_WAKE: begin
            // select activity ignored until delay ends
            // no frame is decoded here, so a stray select change cannot restart anything
            if (dly_r <= 16'h0001) begin
               st_nxt = ST_STBY;
            end else begin
               dly_nxt = dly_r - 16'h0001;
            end
         end
         default: begin
            // unused codes fall back to standby
            st_nxt = ST_STBY;
         end
      endcase
      // hardware reset pins wake from any state
      // placed last so it overrides every branch above
      if (hw_reset) begin
         st_nxt = ST_STBY;
         pend_nxt = 1'b0;
         dly_nxt = 16'h0000;
      end
   end

   // state registers and registered outputs
   always @(posedge mclk) begin
      if (rst) begin
         st_r <= ST_STBY;
         dly_r <= 16'h0000;
         pend_r <= 1'b0;
         power_mode_r <= `SFPM_MODE_STANDBY;
         dev_enabled_r <= 1'b0;
         deep_sleep_state_r <= 1'b0;
         waking_r <= 1'b0;
         dout_en_allow_r <= 1'b0;
         op_start_allow_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         dly_r <= dly_nxt;
         pend_r <= pend_nxt;
         // outputs follow the next state so they line up with the state register
         power_mode_r <= mode_of(st_nxt);
         dev_enabled_r <= sel_active(cs_sel, st_nxt);
         deep_sleep_state_r <= (st_nxt == ST_SLEEP);
         waking_r <= (st_nxt == ST_WAKE);
         // outputs and new operations blocked while asleep
         dout_en_allow_r <= sel_active(cs_sel, st_nxt);
         op_start_allow_r <= (st_nxt == ST_ACT);
      end
   end
endmodule

/* tb/sfpm_checker.sv */
`timescale 1ns/1ns
module sfpm_checker #(
   parameter ENTRY_CYC = 2,
   parameter WAKE_CYC = 2
) (
   // clock, reset and pins
   input wire mclk,
   input wire rst,
   input wire cs_n,
   input wire sck,
   input wire si,
   input wire reset_pin_n,
   input wire shared_io_reset_pin_n,
   input wire [7:0] volatile_status_reg1,
   // state outputs
   input wire [1:0] power_mode_r,
   input wire dev_enabled_r,
   input wire deep_sleep_state_r,
   input wire waking_r,
   input wire dout_en_allow_r,
   input wire op_start_allow_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire rp = reset_pin_n & shared_io_reset_pin_n;
   wire busy = volatile_status_reg1[0];
   reg [7:0] hi_cnt_r;
   reg [7:0] wk_cnt_r;
   // raw select-high and wake lengths; the high count saturates so long idle never wraps
   always @(posedge mclk) begin
      hi_cnt_r <= (rst || !cs_n) ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hff};
      wk_cnt_r <= (rst || !waking_r) ? 8'h00 : wk_cnt_r + 8'h01;
   end
   sequence s_asleep;
      (deep_sleep_state_r || waking_r) [*2];
   endsequence
   chk_select_active: assert property ($fell(cs_n) && power_mode_r != 2'h2 && rp
      |-> ##[2:6] dev_enabled_r && power_mode_r == 2'h1) else $error("select low did not activate");
   chk_busy_active: assert property (power_mode_r == 2'h1 && busy && rp
      |=> power_mode_r == 2'h1) else $error("left active while busy");
   chk_busy_refuse: assert property ($rose(deep_sleep_state_r)
      |-> !$past(busy, 8)) else $error("sleep taken while busy");
   chk_sleep_holds: assert property (power_mode_r == 2'h2 && rp
      |=> power_mode_r == 2'h2 || $past(waking_r) || $past(waking_r, 2)) else $error("sleep left early");
   chk_entry_delay: assert property ($rose(deep_sleep_state_r)
      |-> cs_n && hi_cnt_r >= ENTRY_CYC) else $error("sleep entered too soon");
   chk_wake_delay: assert property ($fell(waking_r) && rp
      |-> wk_cnt_r >= WAKE_CYC ##[0:2] power_mode_r == 2'h0) else $error("wake delay short");
   chk_wake_origin: assert property ($rose(waking_r)
      |-> $past(power_mode_r) == 2'h2 && cs_n) else $error("wake not from sleep");
   chk_sleep_quiet: assert property (s_asleep
      |-> !dout_en_allow_r && !op_start_allow_r) else $error("output allowed in sleep");
endmodule
bind sfpm_ctrl sfpm_checker #(.ENTRY_CYC(ENTRY_CYC), .WAKE_CYC(WAKE_CYC)) chk_u (.mclk(mclk), .rst(rst),
   .cs_n(cs_n), .sck(sck), .si(si), .reset_pin_n(reset_pin_n), .shared_io_reset_pin_n(shared_io_reset_pin_n),
   .volatile_status_reg1(volatile_status_reg1), .power_mode_r(power_mode_r), .dev_enabled_r(dev_enabled_r),
   .deep_sleep_state_r(deep_sleep_state_r), .waking_r(waking_r), .dout_en_allow_r(dout_en_allow_r),
   .op_start_allow_r(op_start_allow_r));

/* tb/sfpm_host.sv */
`timescale 1ns/1ns
module sfpm_host (
   // clock
   input wire mclk,
   // serial pins
   output reg cs_n,
   output reg sck,
   output reg si
);
   integer i;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // framed code, msb first, sck at mclk/4
   task frame(input [7:0] c, input integer n);
      begin
         @(negedge mclk) cs_n = 1'b0;
         for (i = 0; i < n; i = i + 1) begin
            @(negedge mclk) sck = 1'b0;
            si = c[7 - i];
            repeat (2) @(negedge mclk);
            sck = 1'b1;
            @(negedge mclk);
         end
         repeat (2) @(negedge mclk) sck = 1'b0;
         // select rises with clock parked; caller keeps it still through the delay
         cs_n = 1'b1;
         si = ~si;
      end
   endtask
endmodule

/* tb/test_sfpm_ctrl.sv */
`timescale 1ns/1ns
module test_sfpm_ctrl;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [1:0] rpins = 2'h3;
   reg [7:0] status = 8'h00;
   reg [31:0] rnd;
   reg asleep_r = 1'b0;
   reg note_q[$];
   integer error_cnt = 0;
   integer tests_run = 0;
   integer cyc = 0;
   integer k;
   wire cs_n, sck, si, dev_enabled_r, deep_sleep_state_r, waking_r, dout_en_allow_r, op_start_allow_r;
   wire [1:0] power_mode_r;
   initial forever #25 mclk = ~mclk;
   sfpm_host host_u (.mclk(mclk), .cs_n(cs_n), .sck(sck), .si(si));
   // wake delay left at its default so the full figure is exercised
   sfpm_ctrl #(.ENTRY_CYC(5)) dut_u (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
      .reset_pin_n(rpins[0]), .shared_io_reset_pin_n(rpins[1]), .volatile_status_reg1(status),
      .power_mode_r(power_mode_r), .dev_enabled_r(dev_enabled_r), .deep_sleep_state_r(deep_sleep_state_r),
      .waking_r(waking_r), .dout_en_allow_r(dout_en_allow_r), .op_start_allow_r(op_start_allow_r));
   task chk(input [63:0] nm, input [1:0] seen, input [1:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // one frame with fresh random status upper bits, then an idle gap
   task go(input [7:0] c, input integer n, input integer w);
      begin
         rnd = $urandom;
         status[7:1] = rnd[7:1];
         host_u.frame(c, n);
         repeat (w) @(negedge mclk);
      end
   endtask
   // scoreboard: every change of the sleep flag takes the oldest note; a change with no note is a fault
   always @(posedge mclk) begin
      #1;
      if (!rst && (power_mode_r == 2'h2) !== asleep_r) begin
         asleep_r = (power_mode_r == 2'h2);
         if (note_q.size() == 0) chk("note", 2'h1, 2'h0);
         else chk("sleep", {1'b0, asleep_r}, {1'b0, note_q.pop_front()});
      end
      cyc = cyc + 1;
      if (cyc > 20000) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
   end
   initial begin
      rnd = $urandom(99);
      repeat (10) @(negedge mclk);
      rst = 1'b0;
      rnd = $urandom;
      go(rnd[15:8] & 8'h7f, 8, 10);
      chk("mode", power_mode_r, 2'h0);
      $display("test standby done");
      status[0] = 1'b1;
      go(8'hb9, 8, 20);
      chk("mode", power_mode_r, 2'h1);
      chk("start", {1'b0, op_start_allow_r}, 2'h1);
      chk("enabled", {1'b0, dev_enabled_r}, 2'h0);
      status[0] = 1'b0;
      repeat (30) @(negedge mclk);
      chk("sleep", {1'b0, deep_sleep_state_r}, 2'h0);
      $display("test busy done");
      note_q.push_back(1'b1);
      go(8'hb9, 8, 30);
      chk("dout", {1'b0, dout_en_allow_r}, 2'h0);
      chk("start", {1'b0, op_start_allow_r}, 2'h0);
      go(8'h00, 0, 10);
      rnd = $urandom;
      go(rnd[15:8] & 8'h7f, 8, 20);
      chk("mode", power_mode_r, 2'h2);
      note_q.push_back(1'b0);
      go(8'hab, 8, 4);
      chk("waking", {1'b0, waking_r}, 2'h1);
      chk("mode", power_mode_r, 2'h2);
      chk("start", {1'b0, op_start_allow_r}, 2'h0);
      repeat (110) @(negedge mclk);
      chk("mode", power_mode_r, 2'h0);
      $display("test sleep done");
      for (k = 0; k < 2; k = k + 1) begin
         note_q.push_back(1'b1);
         note_q.push_back(1'b0);
         go(8'hb9, 8, 30);
         rpins = k ? 2'h1 : 2'h2;
         repeat (8) @(negedge mclk);
         rpins = 2'h3;
         repeat (10) @(negedge mclk);
         chk("mode", power_mode_r, 2'h0);
      end
      $display("test reset pins done");
      wrap_up;
   end
endmodule
